// ===== hw/fss_device.sv
// What this block does
// - Table of 32 groups at 0x100-0x15F
// - Step select high: advance on chip-select rise
// - Pointer moves in programmed direction
// - Pointer register shows next selected group
// - Direction 0 increments, 1 decrements
// - Increment start to stop, wrap to start
// - Decrement stop to start, wrap to stop
// - Otherwise chip-select rise reloads start or stop
// - Host refreshes pointer after leaving step mode
// - Readback shows codes applied now
// - Reset pin pulse restores all defaults
// - Writing 0x81 soft resets, bits self-clear
// - Host writes 0x3C then reads all back
// - Center function hits Y0-Y9 at breakpoints
// - Bandwidth/match hit coefficients at 0, 32, 255
// - Host loads nominal starting coefficients
// - Calibration one: center 32, set V1/T1
// - Calibration two: center 180, fit V2/T2
// - Calibration three: center 18, fit V0/T0
// - Calibration four: trim every center coefficient
// - Program with step select low, then raise
// - Interpolation only while enable bit set
// - First two segments use shift by four
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module fss_device
  import fss_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Serial link
  fss_link_if.device      link,
  // Applied filter codes
  output logic [7:0]      center_code_o,
  output logic [7:0]      bandwidth_code_o,
  output logic [7:0]      match_code_o
);
  import fss_pkg::*;

  function automatic logic [7:0] center_fn(input logic [7:0] x,
                                           input logic [COEF_N-1:0][7:0] c);
    int seg;
    int p;
    seg = 0;
    for (int k = 1; k < 9; k++)
      if (int'(x) >= FC_BP[k])
        seg = k;
    p = (FC_BP[seg+1] - int'(x)) * (int'(c[seg]) - int'(c[seg+1]));
    p = (seg < 2) ? (p >>> 4) : (p >>> 5);
    if (int'(x) == X_TOP)
      center_fn = c[9];
    else
      center_fn = 8'(int'(c[seg+1]) + p);
  endfunction : center_fn

  function automatic logic [7:0] vt_fn(input logic [7:0] y,
                                       input logic [7:0] c0,
                                       input logic [7:0] c1,
                                       input logic [7:0] c2);
    int p;
    p = 0;
    if (int'(y) < VT_KNEE)
    begin
      p = (int'(y) * (int'(c1) - int'(c0))) >>> 5;
      vt_fn = 8'(int'(c0) + p);
    end
    else if (int'(y) < X_TOP)
    begin
      p = ((int'(y) - VT_KNEE) * (int'(c2) - int'(c1)) * VT_SCALE) >>> VT_SHIFT;
      vt_fn = 8'(int'(c1) + p);
    end
    else
      vt_fn = c2;
  endfunction : vt_fn

  // Pin synchronisers; stage one feeds stage two only
  logic [4:0]             pin_s1_reg;
  logic [4:0]             pin_s2_reg;
  logic [4:0]             pin_s3_reg;
  logic [7:0]             cfg_reg;
  logic [6:0]             stop_reg;
  logic [6:0]             start_reg;
  logic                   dir_reg;
  logic [6:0]             ptr_reg;
  logic [4:0]             grp_reg;
  logic [2:0][7:0]        wr_reg;
  logic                   interp_reg;
  logic [COEF_N-1:0][7:0] coef_reg;
  logic [7:0]             lut_reg [LUT_BYTES];
  logic [2:0][7:0]        applied_reg;
  logic [CNT_W-1:0]       cnt_reg;
  logic [15:0]            hdr_reg;
  logic [7:0]             rx_reg;
  logic [7:0]             tx_reg;
  logic [14:0]            addr_reg;
  logic                   sdo_reg;
  logic                   sdo_oe_n_reg;
  logic [7:0]             rd_byte;

  wire sclk_rise = pin_s2_reg[0] & ~pin_s3_reg[0];
  wire sclk_fall = ~pin_s2_reg[0] & pin_s3_reg[0];
  wire cs_low    = ~pin_s2_reg[1];
  wire cs_rise   = pin_s2_reg[1] & ~pin_s3_reg[1];
  wire sdi_s     = pin_s2_reg[2];
  wire step_mode = pin_s2_reg[3];
  wire hard_rst  = ~pin_s2_reg[4];
  // Soft reset takes one cycle after the write, then clears itself
  wire soft_rst  = cfg_reg[SOFT_BIT] | cfg_reg[SOFT_MIR];
  wire clr       = rst_i | hard_rst | soft_rst;

  wire in_data   = cnt_reg >= CNT_W'(HDR_BITS);
  wire is_read   = hdr_reg[15];
  wire wr_en     = sclk_rise & cs_low & in_data & ~is_read & (cnt_reg[2:0] == 3'h7);
  wire rd_load   = sclk_fall & cs_low & in_data & is_read & (cnt_reg[2:0] == 3'h0);
  wire [7:0] wr_data = {rx_reg[6:0], sdi_s};

  wire       is_lut   = (addr_reg >= A_LUT) && (addr_reg <= A_LUT_END);
  wire [6:0] lut_idx  = 7'(addr_reg - A_LUT);
  wire       is_coef  = (addr_reg >= A_COEF) && (addr_reg < A_COEF + 15'(COEF_N));
  wire [3:0] coef_idx = 4'(addr_reg - A_COEF);

  // Sequencer next pointer
  wire [6:0] ptr_inc  = (ptr_reg == stop_reg) ? start_reg : 7'(ptr_reg + 7'h1);
  wire [6:0] ptr_dec  = (ptr_reg == start_reg) ? stop_reg : 7'(ptr_reg - 7'h1);
  wire [6:0] ptr_step = dir_reg ? ptr_dec : ptr_inc;
  wire [6:0] ptr_home = dir_reg ? stop_reg : start_reg;

  // Code source: latched table group in step mode, write group otherwise
  wire [6:0] grp_base = 7'(grp_reg * 3);
  wire [7:0] fc_raw   = step_mode ? lut_reg[grp_base] : wr_reg[0];
  wire [7:0] bw_raw   = step_mode ? lut_reg[7'(grp_base + 7'h1)] : wr_reg[1];
  wire [7:0] mt_raw   = step_mode ? lut_reg[7'(grp_base + 7'h2)] : wr_reg[2];
  wire [7:0] y_val    = center_fn(fc_raw, coef_reg);
  wire [7:0] v_val    = vt_fn(y_val, coef_reg[C_V0], coef_reg[C_V0+1], coef_reg[C_V0+2]);
  wire [7:0] t_val    = vt_fn(y_val, coef_reg[C_T0], coef_reg[C_T0+1], coef_reg[C_T0+2]);
  wire [7:0] fc_app   = interp_reg ? y_val : fc_raw;
  wire [7:0] bw_app   = interp_reg ? v_val : bw_raw;
  wire [7:0] mt_app   = interp_reg ? t_val : mt_raw;

  always_comb
  begin
    case (addr_reg)
      A_CFG:   rd_byte = cfg_reg;
      A_STOP:  rd_byte = {1'b0, stop_reg};
      A_START: rd_byte = {1'b0, start_reg};
      A_DIR:   rd_byte = {7'h00, dir_reg};
      A_PTR:   rd_byte = {1'b0, ptr_reg};
      A_WR_FC: rd_byte = wr_reg[0];
      A_WR_BW: rd_byte = wr_reg[1];
      A_WR_MT: rd_byte = wr_reg[2];
      A_FCFG:  rd_byte = {7'h00, interp_reg};
      A_RB_FC: rd_byte = applied_reg[0];
      A_RB_BW: rd_byte = applied_reg[1];
      A_RB_MT: rd_byte = applied_reg[2];
      default: rd_byte = is_lut ? lut_reg[lut_idx] : (is_coef ? coef_reg[coef_idx] : 8'h00);
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_reg <= PIN_IDLE;
      pin_s2_reg <= PIN_IDLE;
      pin_s3_reg <= PIN_IDLE;
    end
    else
    begin
      pin_s1_reg <= {link.rst_n, link.table_step_select, link.sdi, link.cs_n, link.sclk};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // Serial shifter; a frame streams on to ascending addresses
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !cs_low)
    begin
      cnt_reg      <= '0;
      hdr_reg      <= 16'h0000;
      rx_reg       <= 8'h00;
      tx_reg       <= 8'h00;
      addr_reg     <= 15'h0000;
      sdo_reg      <= 1'b0;
      sdo_oe_n_reg <= 1'b1;
    end
    else
    begin
      if (sclk_rise)
      begin
        cnt_reg <= CNT_W'(cnt_reg + 1'b1);
        if (!in_data)
          hdr_reg <= {hdr_reg[14:0], sdi_s};
        else
          rx_reg <= wr_data;
        if (cnt_reg == CNT_W'(HDR_BITS - 1))
          addr_reg <= {hdr_reg[13:0], sdi_s};
        else if (wr_en)
          addr_reg <= 15'(addr_reg + 15'h1);
      end
      if (rd_load)
      begin
        sdo_reg      <= rd_byte[7];
        tx_reg       <= {rd_byte[6:0], 1'b0};
        addr_reg     <= 15'(addr_reg + 15'h1);
        sdo_oe_n_reg <= 1'b0;
      end
      else if (sclk_fall && in_data && is_read)
      begin
        sdo_reg <= tx_reg[7];
        tx_reg  <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // Register file; all of it returns to defaults on any reset
  always_ff @(posedge clk_i)
  begin
    if (clr)
    begin
      cfg_reg    <= 8'h00;
      stop_reg   <= STOP_RST;
      start_reg  <= START_RST;
      dir_reg    <= 1'b0;
      wr_reg     <= '0;
      interp_reg <= 1'b0;
      coef_reg   <= '0;
      for (int i = 0; i < LUT_BYTES; i++)
        lut_reg[i] <= 8'h00;
    end
    else if (wr_en)
    begin
      case (addr_reg)
        A_CFG:   cfg_reg    <= wr_data;
        A_STOP:  stop_reg   <= wr_data[6:0];
        A_START: start_reg  <= wr_data[6:0];
        A_DIR:   dir_reg    <= wr_data[DIR_BIT];
        A_WR_FC: wr_reg[0]  <= wr_data;
        A_WR_BW: wr_reg[1]  <= wr_data;
        A_WR_MT: wr_reg[2]  <= wr_data;
        A_FCFG:  interp_reg <= wr_data[INTERP_BIT];
        default:
        begin
          if (is_lut)
            lut_reg[lut_idx] <= wr_data;
          else if (is_coef)
            coef_reg[coef_idx] <= wr_data;
        end
      endcase
    end
  end

  // Sequencer steps on the chip-select rise only
  always_ff @(posedge clk_i)
  begin
    if (clr)
    begin
      ptr_reg <= START_RST;
      grp_reg <= 5'h00;
    end
    else if (cs_rise)
    begin
      if (step_mode)
      begin
        grp_reg <= ptr_reg[4:0];
        ptr_reg <= ptr_step;
      end
      else
        ptr_reg <= ptr_home;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (clr)
      applied_reg <= '0;
    else
      applied_reg <= {mt_app, bw_app, fc_app};
  end

  assign link.sdo         = sdo_reg;
  assign link.sdo_oe_n    = sdo_oe_n_reg;
  assign center_code_o    = applied_reg[0];
  assign bandwidth_code_o = applied_reg[1];
  assign match_code_o     = applied_reg[2];
endmodule : fss_device
`default_nettype wire

// ===== hw/fss_host.sv
`timescale 1ns/1ps
`default_nettype none
module fss_host
  import fss_pkg::*;
#(
  parameter int HALF = SCLK_HALF
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Serial link
  fss_link_if.host         link
);
  import fss_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TRAIL, H_GAP} fss_hstate_type;

  fss_hstate_type state_reg;
  logic [23:0]    cmd_reg;
  logic [23:0]    sh_reg;
  logic [7:0]     rx_reg;
  logic [4:0]     bits_reg;
  logic [7:0]     tmr_reg;
  logic           sclk_reg;
  logic           cs_n_reg;
  logic           sdi_reg;
  logic           step_sel_reg;
  logic           rst_n_reg;
  logic           ack_reg;
  logic [31:0]    dat_reg;
  logic           sdo_s1_reg;
  logic           sdo_s2_reg;

  wire        req     = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire        busy    = state_reg != H_IDLE;
  wire        wr      = req & wb_we_i & ~busy;
  wire        go_cmd  = wr & (wb_adr_i == H_CMD) & wb_sel_i[0];
  wire        go_puls = wr & (wb_adr_i == H_CTRL) & wb_sel_i[0] & wb_dat_i[2];
  wire        tick    = tmr_reg == 8'h00;
  wire [7:0]  reload  = 8'(HALF - 1);
  wire [31:0] rd_mux  = (wb_adr_i == H_CMD)  ? {8'h00, cmd_reg} :
                        (wb_adr_i == H_STAT) ? {16'h0000, rx_reg, 7'h00, busy} :
                        (wb_adr_i == H_CTRL) ? {30'h0, ~rst_n_reg, step_sel_reg} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0;
      cmd_reg   <= 24'h0;
      step_sel_reg <= 1'b0;
      rst_n_reg <= 1'b1;
    end
    else
    begin
      ack_reg <= req;
      dat_reg <= req ? rd_mux : 32'h0;
      if (wr && wb_adr_i == H_CMD)
      begin
        cmd_reg[7:0] <= wb_sel_i[0] ? wb_dat_i[7:0] : cmd_reg[7:0];
        cmd_reg[15:8] <= wb_sel_i[1] ? wb_dat_i[15:8] : cmd_reg[15:8];
        cmd_reg[23:16] <= wb_sel_i[2] ? wb_dat_i[23:16] : cmd_reg[23:16];
      end
      if (wr && wb_adr_i == H_CTRL && wb_sel_i[0])
      begin
        step_sel_reg <= wb_dat_i[0];
        rst_n_reg <= ~wb_dat_i[1];
      end
    end
  end

  // Frame engine; sclk idles low, data changes on the falling edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= H_IDLE;
      sh_reg    <= 24'h0;
      rx_reg    <= 8'h00;
      bits_reg  <= 5'h00;
      tmr_reg   <= 8'h00;
      sclk_reg  <= 1'b0;
      cs_n_reg  <= 1'b1;
      sdi_reg   <= 1'b0;
      sdo_s1_reg <= 1'b1;
      sdo_s2_reg <= 1'b1;
    end
    else
    begin
      sdo_s1_reg <= link.sdo_line;
      sdo_s2_reg <= sdo_s1_reg;
      tmr_reg    <= tick ? reload : 8'(tmr_reg - 8'h1);
      case (state_reg)
        H_IDLE:
        begin
          tmr_reg <= reload;
          if (go_cmd || go_puls)
          begin
            state_reg <= H_LEAD;
            cs_n_reg  <= 1'b0;
            sh_reg    <= {wb_sel_i[2] ? wb_dat_i[23:16] : cmd_reg[23:16],
                          wb_sel_i[1] ? wb_dat_i[15:8] : cmd_reg[15:8], wb_dat_i[7:0]};
            bits_reg  <= go_cmd ? 5'(FRAME_BITS) : 5'h00;
          end
        end
        H_LEAD, H_HIGH:
          if (tick)
          begin
            sclk_reg <= 1'b0;
            if ((state_reg == H_HIGH && bits_reg == 5'h01) || bits_reg == 5'h00)
              state_reg <= H_TRAIL;
            else
            begin
              state_reg <= H_LOW;
              sdi_reg   <= sh_reg[23];
              sh_reg    <= {sh_reg[22:0], 1'b0};
            end
            if (state_reg == H_HIGH)
              bits_reg <= 5'(bits_reg - 5'h01);
          end
        H_LOW:
          if (tick)
          begin
            sclk_reg  <= 1'b1;
            rx_reg    <= {rx_reg[6:0], sdo_s2_reg};
            state_reg <= H_HIGH;
          end
        H_TRAIL:
          if (tick)
          begin
            cs_n_reg  <= 1'b1;
            state_reg <= H_GAP;
          end
        H_GAP:
          if (tick)
            state_reg <= H_IDLE;
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  assign wb_ack_o               = ack_reg;
  assign wb_dat_o               = dat_reg;
  assign link.sclk              = sclk_reg;
  assign link.cs_n              = cs_n_reg;
  assign link.sdi               = sdi_reg;
  assign link.table_step_select = step_sel_reg;
  assign link.rst_n             = rst_n_reg;
endmodule : fss_host
`default_nettype wire

// ===== hw/fss_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fss_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  logic table_step_select;
  logic rst_n;
  logic sdo_line;
  // Pulled high while the device does not drive
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo;
  modport device (
    input  sclk, cs_n, sdi, table_step_select, rst_n,
    output sdo, sdo_oe_n
  );
  modport host (
    output sclk, cs_n, sdi, table_step_select, rst_n,
    input  sdo_line
  );
endinterface : fss_link_if
`default_nettype wire

// ===== hw/fss_pkg.sv
package fss_pkg;
  // Serial frame: R/W bit, 15 address bits, then data bytes
  localparam int          HDR_BITS   = 16;
  localparam int          ADDR_W     = 15;
  localparam int          CNT_W      = 12;
  // Device register offsets
  localparam logic [14:0] A_CFG      = 15'h000;
  localparam logic [14:0] A_STOP     = 15'h011;
  localparam logic [14:0] A_START    = 15'h012;
  localparam logic [14:0] A_DIR      = 15'h013;
  localparam logic [14:0] A_PTR      = 15'h014;
  localparam logic [14:0] A_WR_FC    = 15'h020;
  localparam logic [14:0] A_WR_BW    = 15'h021;
  localparam logic [14:0] A_WR_MT    = 15'h022;
  localparam logic [14:0] A_COEF     = 15'h030;
  localparam logic [14:0] A_FCFG     = 15'h050;
  localparam logic [14:0] A_RB_FC    = 15'h060;
  localparam logic [14:0] A_RB_BW    = 15'h061;
  localparam logic [14:0] A_RB_MT    = 15'h062;
  localparam logic [14:0] A_LUT      = 15'h100;
  localparam logic [14:0] A_LUT_END  = 15'h15f;
  localparam int          LUT_GROUPS = 32;
  localparam int          LUT_BYTES  = 96;
  localparam int          COEF_N     = 16;
  // Coefficient slots: center 0..9, bandwidth 10..12, match 13..15
  localparam int          C_V0       = 10;
  localparam int          C_T0       = 13;
  // Reset values and field positions
  localparam logic [6:0]  STOP_RST   = 7'h7f;
  localparam logic [6:0]  START_RST  = 7'h00;
  localparam int          SOFT_BIT   = 0;
  localparam int          SOFT_MIR   = 7;
  localparam int          INTERP_BIT = 0;
  localparam int          DIR_BIT    = 0;
  // Synchronised pin order: sclk, cs_n, sdi, step select, rst_n
  localparam logic [4:0]  PIN_IDLE   = 5'h12;
  // Interpolation breakpoints and arithmetic
  localparam int          FC_BP [10] = '{0, 16, 32, 64, 96, 128, 160, 192, 224, 256};
  localparam int          X_TOP      = 255;
  localparam int          VT_KNEE    = 32;
  localparam int          VT_SCALE   = 295;
  localparam int          VT_SHIFT   = 16;
  // Controller register byte offsets
  localparam logic [3:0]  H_CMD      = 4'h0;
  localparam logic [3:0]  H_STAT     = 4'h4;
  localparam logic [3:0]  H_CTRL     = 4'h8;
  localparam int          FRAME_BITS = 24;
  localparam int          SCLK_HALF  = 8;
endpackage : fss_pkg

// ===== verif/fss_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module fss_link_props
(
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Link pins
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       sdi,
  input wire logic       sdo_oe_n,
  input wire logic       table_step_select,
  input wire logic       rst_n,
  // Applied codes
  input wire logic [7:0] center_code_o,
  input wire logic [7:0] bandwidth_code_o,
  input wire logic [7:0] match_code_o
);
  logic        cs_reg;
  logic        sclk_reg;
  logic        sel_reg;
  logic [23:0] shift_reg;
  logic [5:0]  bits_reg;
  logic [3:0]  cs_age_reg;
  logic [3:0]  rn_age_reg;
  logic [3:0]  sf_age_reg;
  wire         cs_rise = cs_n & ~cs_reg;
  wire         bit_in  = sclk & ~sclk_reg & ~cs_n;
  wire  [23:0] codes   = {center_code_o, bandwidth_code_o, match_code_o};
  // Synchronisers delay every pin, so allow a margin after each event
  wire         settled = cs_n && cs_age_reg > 4'h8 && rn_age_reg > 4'h8 && sf_age_reg > 4'h8;

  always_ff @(posedge clk_i)
  begin
    cs_reg     <= cs_n;
    sclk_reg   <= sclk;
    sel_reg    <= table_step_select;
    shift_reg  <= bit_in ? {shift_reg[22:0], sdi} : shift_reg;
    bits_reg   <= (rst_i || (cs_reg && !cs_n)) ? 6'h00 : bits_reg + {5'h00, bit_in};
    cs_age_reg <= (rst_i || cs_rise) ? 4'h0 : cs_age_reg + {3'h0, cs_age_reg != 4'hf};
    rn_age_reg <= (rst_i || !rst_n) ? 4'h0 : rn_age_reg + {3'h0, rn_age_reg != 4'hf};
    sf_age_reg <= (rst_i || table_step_select != sel_reg) ? 4'h0
                  : sf_age_reg + {3'h0, sf_age_reg != 4'hf};
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_rst_pulse;
    $fell(rst_n) |-> !rst_n [*3];
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset pin pulse shorter than three clocks");

  property p_rst_clear;
    !rst_n [*3] |-> ##[0:6] (codes == 24'h000000);
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("codes not cleared by reset pin");

  property p_soft_clear;
    cs_rise && bits_reg == 6'h18 && shift_reg == 24'h000081 |-> ##[0:8] (codes == 24'h000000);
  endproperty
  a_soft_clear: assert property (p_soft_clear)
    else $error("codes not cleared by soft reset");

  property p_sfl_quiet;
    $changed(table_step_select) |-> cs_n && !sclk;
  endproperty
  a_sfl_quiet: assert property (p_sfl_quiet)
    else $error("step select changed inside a frame");

  property p_step_hold;
    settled && table_step_select |=> $stable(codes);
  endproperty
  a_step_hold: assert property (p_step_hold)
    else $error("step mode codes changed without chip-select rise");

  property p_write_hold;
    settled && !table_step_select |=> $stable(codes);
  endproperty
  a_write_hold: assert property (p_write_hold)
    else $error("write mode codes changed between frames");

  property p_sclk_idle;
    cs_n |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock high while deselected");

  property p_sdo_idle;
    cs_n [*8] |-> sdo_oe_n;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("data out driven while deselected");
endmodule : fss_link_props
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fss_pkg::*;
  logic        clk_i           = 1'b0;
  logic        rst_i           = 1'b1;
  logic        wb_cyc          = 1'b0;
  logic        wb_stb          = 1'b0;
  logic        wb_we           = 1'b0;
  logic [3:0]  wb_adr          = 4'h0;
  logic [31:0] wb_dat          = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [7:0]  fc;
  logic [7:0]  bw;
  logic [7:0]  mt;
  int          n_mismatch      = 0;
  int          samples_checked = 0;

  always #12.5 clk_i = ~clk_i;

  fss_link_if link ();
  fss_host #(.HALF(8)) fss_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(link));
  fss_device fss_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .center_code_o(fc), .bandwidth_code_o(bw), .match_code_o(mt));
  fss_link_props fss_link_props_inst (.clk_i(clk_i), .rst_i(rst_i), .sclk(link.sclk),
    .cs_n(link.cs_n), .sdi(link.sdi), .sdo_oe_n(link.sdo_oe_n),
    .table_step_select(link.table_step_select), .rst_n(link.rst_n),
    .center_code_o(fc), .bandwidth_code_o(bw), .match_code_o(mt));

  task automatic end_sim;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk_codes(input logic [7:0] c, input logic [7:0] b, input logic [7:0] m);
    chk8(fc, c, "center code");
    chk8(bw, b, "bandwidth code");
    chk8(mt, m, "match code");
  endtask : chk_codes

  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    do
      @(posedge clk_i);
    while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb

  task automatic dev(input logic rd, input logic [14:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [31:0] r;
    wb(1'b1, H_CMD, {8'h00, rd, a, d}, r);
    do
      wb(1'b0, H_STAT, 32'h0, r);
    while (r[0] !== 1'b0);
    q = r[15:8];
  endtask : dev

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    dev(1'b0, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] q;
    dev(1'b1, a, 8'h00, q);
    chk8(q, e, "register read");
  endtask : rd_chk

  // Busy covers a chip-select pulse but not a step select or reset pin change, so also wait out the pin delay
  task automatic ctrl(input logic [2:0] v);
    logic [31:0] r;
    wb(1'b1, H_CTRL, {29'h0, v}, r);
    do
      wb(1'b0, H_STAT, 32'h0, r);
    while (r[0] !== 1'b0);
    wait (link.cs_n === 1'b1);
    repeat (8) @(posedge clk_i);
  endtask : ctrl

  task automatic t_defaults;
    logic [14:0] a [8] = '{A_CFG, A_STOP, A_START, A_DIR, A_PTR, A_RB_FC, A_RB_BW, A_RB_MT};
    logic [7:0]  e [8] = '{8'h00, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [31:0] r;
    for (int i = 0; i < 8; i++)
      rd_chk(a[i], e[i]);
    wb(1'b0, 4'hc, 32'h0, r);
    chk8(r[7:0], 8'h00, "unmapped read");
  endtask : t_defaults

  task automatic t_write_mode;
    wr(A_WR_BW, 8'h3c);
    wr(A_WR_MT, 8'h71);
    wr(A_WR_FC, 8'ha5);
    chk_codes(8'ha5, 8'h3c, 8'h71);
    rd_chk(A_RB_FC, 8'ha5);
    rd_chk(A_RB_BW, 8'h3c);
    rd_chk(A_RB_MT, 8'h71);
  endtask : t_write_mode

  task automatic t_step(input logic dir);
    logic [7:0] g;
    logic [31:0] r;
    for (int i = 2; i < 5; i++)
    begin
      wr(A_LUT + 15'(3 * i), 8'h40 + 8'(i));
      wr(A_LUT + 15'(3 * i + 1), 8'h80 + 8'(i));
      wr(A_LUT + 15'(3 * i + 2), 8'hc0 + 8'(i));
    end
    wr(A_START, 8'h02);
    wr(A_STOP, 8'h04);
    wr(A_DIR, {7'h00, dir});
    rd_chk(A_PTR, dir ? 8'h04 : 8'h02);
    ctrl(3'h1);
    wb(1'b0, H_CTRL, 32'h0, r);
    chk8(r[7:0], 8'h01, "control read");
    for (int i = 0; i < 4; i++)
    begin
      ctrl(3'h5);
      g = dir ? 8'(4 - i % 3) : 8'(2 + i % 3);
      chk_codes(8'h40 + g, 8'h80 + g, 8'hc0 + g);
    end
    ctrl(3'h0);
    rd_chk(A_PTR, 8'h03);
    rd_chk(A_PTR, dir ? 8'h04 : 8'h02);
  endtask : t_step

  task automatic t_interp;
    logic [7:0] y [10] = '{8'hef, 8'hc9, 8'ha9, 8'h78, 8'h5b, 8'h44, 8'h33, 8'h27, 8'h1c, 8'h14};
    logic [7:0] x [10] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h60, 8'h80, 8'ha0, 8'hc0, 8'he0, 8'hff};
    logic [7:0] vt [6] = '{8'h00, 8'h05, 8'h40, 8'h05, 8'h1e, 8'hb2};
    wr(A_FCFG, 8'h01);
    for (int i = 0; i < 10; i++)
      wr(A_COEF + 15'(i), y[i]);
    for (int i = 0; i < 6; i++)
      wr(A_COEF + 15'(C_V0 + i), vt[i]);
    for (int i = 0; i < 10; i++)
    begin
      wr(A_WR_FC, x[i]);
      chk8(fc, y[i], "center breakpoint");
    end
    wr(A_WR_FC, 8'h08);
    chk8(fc, 8'hdc, "first segment");
    // Centre outputs of 255, 32 and 0 land on the bandwidth breakpoints
    wr(A_COEF, 8'hff);
    wr(A_COEF + 15'h1, 8'h20);
    wr(A_COEF + 15'h2, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(A_WR_FC, x[i]);
      chk_codes(i == 0 ? 8'hff : i == 1 ? 8'h20 : 8'h00, vt[2 - i], vt[5 - i]);
    end
    rd_chk(A_RB_MT, 8'h05);
    // High and low calibration points run through both segments of v and t
    wr(A_WR_FC, 8'hb4);
    chk_codes(8'h2b, 8'h07, 8'h25);
    wr(A_WR_FC, 8'h12);
    chk_codes(8'h1c, 8'h04, 8'h1a);
    wr(A_FCFG, 8'h00);
    wr(A_WR_FC, 8'h08);
    chk_codes(8'h08, 8'h3c, 8'h71);
  endtask : t_interp

  task automatic t_soft_reset;
    wr(A_START, 8'h05);
    wr(A_CFG, 8'h81);
    rd_chk(A_CFG, 8'h00);
    rd_chk(A_START, 8'h00);
    chk_codes(8'h00, 8'h00, 8'h00);
  endtask : t_soft_reset

  task automatic t_hard_reset;
    wr(A_START, 8'h06);
    wr(A_WR_FC, 8'h11);
    ctrl(3'h2);
    ctrl(3'h0);
    chk_codes(8'h00, 8'h00, 8'h00);
    rd_chk(A_START, 8'h00);
    wr(A_CFG, 8'h3c);
    rd_chk(A_CFG, 8'h3c);
  endtask : t_hard_reset

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_defaults;
    t_write_mode;
    t_step(1'b0);
    t_step(1'b1);
    t_interp;
    t_soft_reset;
    t_hard_reset;
    end_sim;
  end

  // About twice the expected run length
  initial
  begin
    #2000000;
    n_mismatch++;
    end_sim;
  end
endmodule : testbench
`default_nettype wire
